// ==== core/art_defs.svh ====
// Purpose: shared constants of the acquisition stop and pause trigger block
// Assumes: included by its bare name
// Notes: source indices address the flattened source vectors
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

// ----------------------------------------------------------------
// pin and source counts
// ----------------------------------------------------------------
`define ART_NUM_PFI 16
`define ART_NUM_BUS 8
`define ART_NUM_CTR 4
`define ART_NUM_OTHER 3
`define ART_SRC_W 6
`define ART_VEC_W 64

// ----------------------------------------------------------------
// stop trigger source map
// ----------------------------------------------------------------
`define ART_REF_SRC_PFI0 0
`define ART_REF_SRC_BUS0 16
`define ART_REF_SRC_STAR 24
`define ART_REF_SRC_CHG 25
`define ART_REF_SRC_CTR0 26
`define ART_REF_SRC_OTHER0 30
`define ART_REF_SRC_CMP 33

// ----------------------------------------------------------------
// pause gate source map
// ----------------------------------------------------------------
`define ART_PAU_SRC_PFI0 0
`define ART_PAU_SRC_BUS0 16
`define ART_PAU_SRC_STAR 24
`define ART_PAU_SRC_CTR0 25
`define ART_PAU_SRC_GATE0 29
`define ART_PAU_SRC_OTHER0 33
`define ART_PAU_SRC_CMP 36

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ART_RST_OE 1'b0
`define ART_RST_LEVEL 1'b0

`endif

// ==== core/art_pkg.sv ====
// Purpose: types of the acquisition stop and pause trigger block
// Assumes: nothing
// Notes: one-hot acquisition states
package art_pkg;

	// ----------------------------------------------------------------
	// acquisition states
	// ----------------------------------------------------------------
	typedef enum logic [4:0]
	{
		ART_IDLE = 5'h01,
		ART_PRE = 5'h02,
		ART_ARMED = 5'h04,
		ART_POST = 5'h08,
		ART_DONE = 5'h10
	} art_state_t;

endpackage

// ==== core/art_sync.sv ====
// Purpose: two flop synchroniser for asynchronous levels
// Assumes: inputs are quasi static compared to sys_clk
// Notes: first stage is read only by the second stage
module art_sync
#(
	parameter int W = 1
)
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '0;
			q_r <= '0;
		end
		else
		begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;

endmodule

// ==== core/art_trigger.sv ====
// Purpose: stop trigger and pause gate control of a sampled acquisition
// Assumes: samples, counters and subsystem triggers are on sys_clk; pins and comparator are not
// Notes: buffer storage lives outside, this block steers its write side
// Operation
// - posttrigger count is buffer size minus pretrigger
// - watch stop trigger after pretrigger samples stored
// - early stop conditions are ignored
// - full buffer overwrites oldest sample circularly
// - capture exactly posttrigger count then finish
// - digital stop source uses selected edge
// - comparator stop source uses rising edge
// - stop source chosen from multiplexed sources
// - stop trigger routable to pins and lines
// - function pins reset as inputs only
// - active pause suppresses sample strobes
// - pause active level is programmable
// - pause reacts to level, never edges
// - comparator pause follows its selected level
// - pause source and polarity are selectable
// - pause gate routable to pins and lines
// - strobes ignored outside an acquisition
// - begin on start trigger or software command
// - stop trigger never restarts a capture
`include "art_defs.svh"

module art_trigger
#(
	parameter int CNT_W = 16,
	parameter int DATA_W = 16
)
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [CNT_W-1:0] cfg_buf_size,
	input wire logic [CNT_W-1:0] cfg_pre_count,
	input wire logic cfg_ref_enable,
	input wire logic [`ART_SRC_W-1:0] cfg_ref_src,
	input wire logic cfg_ref_edge_fall,
	input wire logic cfg_start_use_trig,
	input wire logic sw_start,
	input wire logic sw_stop,
	input wire logic acq_begin_trigger,
	input wire logic cfg_pause_enable,
	input wire logic [`ART_SRC_W-1:0] cfg_pause_src,
	input wire logic cfg_pause_active_low,
	input wire logic [`ART_NUM_PFI-1:0] cfg_pfi_ref_out,
	input wire logic [`ART_NUM_PFI-1:0] cfg_pfi_pause_out,
	input wire logic [`ART_NUM_BUS-1:0] cfg_bus_ref_out,
	input wire logic [`ART_NUM_BUS-1:0] cfg_bus_pause_out,
	input wire logic cfg_star_ref_out,
	input wire logic cfg_star_pause_out,
	input wire logic [`ART_NUM_PFI-1:0] programmable_function_pin_in,
	output logic [`ART_NUM_PFI-1:0] programmable_function_pin_out,
	output logic [`ART_NUM_PFI-1:0] programmable_function_pin_oe,
	input wire logic [`ART_NUM_BUS-1:0] sync_trigger_bus_line_in,
	output logic [`ART_NUM_BUS-1:0] sync_trigger_bus_line_out,
	output logic [`ART_NUM_BUS-1:0] sync_trigger_bus_line_oe,
	input wire logic star_in,
	output logic star_output_line,
	input wire logic comparator_in,
	input wire logic change_detect,
	input wire logic [`ART_NUM_CTR-1:0] ctr_out,
	input wire logic [`ART_NUM_CTR-1:0] ctr_gate,
	input wire logic [`ART_NUM_OTHER-1:0] other_stop_trig,
	input wire logic [`ART_NUM_OTHER-1:0] other_pause_trig,
	input wire logic acq_sample_strobe_in,
	input wire logic [DATA_W-1:0] sample_data,
	output logic acq_sample_strobe,
	output logic buf_wr_en,
	output logic [CNT_W-1:0] buf_wr_addr,
	output logic [DATA_W-1:0] buf_wr_data,
	output logic [CNT_W-1:0] trig_addr,
	output logic buf_wrapped,
	output logic acq_stop_trigger,
	output logic acq_pause_gate,
	output logic acq_running,
	output logic acq_done
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed
	{
		art_pkg::art_state_t state;
		logic [CNT_W-1:0] wr_addr;
		logic [CNT_W-1:0] fill;
		logic [CNT_W-1:0] post_cnt;
		logic [CNT_W-1:0] post_tgt;
		logic [CNT_W-1:0] trig_addr;
		logic wrapped;
		logic ref_prev;
		logic stop_pulse;
		logic done_pulse;
		logic pause;
		logic wr_en;
		logic [DATA_W-1:0] wr_data;
		logic [`ART_NUM_PFI-1:0] pfi_out;
		logic [`ART_NUM_PFI-1:0] pfi_oe;
		logic [`ART_NUM_BUS-1:0] bus_out;
		logic [`ART_NUM_BUS-1:0] bus_oe;
		logic star_out;
	} art_regs_t;

	localparam art_regs_t ST_RESET = '{state: art_pkg::ART_IDLE, default: '0};

	art_regs_t st_r;
	art_regs_t st_nxt;

	// ----------------------------------------------------------------
	// source selection
	// ----------------------------------------------------------------
	function automatic logic src_pick(input logic [`ART_VEC_W-1:0] v, input logic [`ART_SRC_W-1:0] s);
		return v[s];
	endfunction

	logic [`ART_NUM_PFI-1:0] pfi_s;
	logic [`ART_NUM_BUS-1:0] bus_s;
	logic star_s;
	logic cmp_s;
	logic [`ART_VEC_W-1:0] ref_vec;
	logic [`ART_VEC_W-1:0] pause_vec;

	art_sync
	#(
		.W(`ART_NUM_PFI + `ART_NUM_BUS + 2)
	)
	u_sync
	(
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.d({comparator_in, star_in, sync_trigger_bus_line_in, programmable_function_pin_in}),
		.q({cmp_s, star_s, bus_s, pfi_s})
	);

	always_comb
	begin
		ref_vec = '0;
		ref_vec[`ART_REF_SRC_PFI0 +: `ART_NUM_PFI] = pfi_s;
		ref_vec[`ART_REF_SRC_BUS0 +: `ART_NUM_BUS] = bus_s;
		ref_vec[`ART_REF_SRC_STAR] = star_s;
		ref_vec[`ART_REF_SRC_CHG] = change_detect;
		ref_vec[`ART_REF_SRC_CTR0 +: `ART_NUM_CTR] = ctr_out;
		ref_vec[`ART_REF_SRC_OTHER0 +: `ART_NUM_OTHER] = other_stop_trig;
		ref_vec[`ART_REF_SRC_CMP] = cmp_s;
	end

	always_comb
	begin
		pause_vec = '0;
		pause_vec[`ART_PAU_SRC_PFI0 +: `ART_NUM_PFI] = pfi_s;
		pause_vec[`ART_PAU_SRC_BUS0 +: `ART_NUM_BUS] = bus_s;
		pause_vec[`ART_PAU_SRC_STAR] = star_s;
		pause_vec[`ART_PAU_SRC_CTR0 +: `ART_NUM_CTR] = ctr_out;
		pause_vec[`ART_PAU_SRC_GATE0 +: `ART_NUM_CTR] = ctr_gate;
		pause_vec[`ART_PAU_SRC_OTHER0 +: `ART_NUM_OTHER] = other_pause_trig;
		pause_vec[`ART_PAU_SRC_CMP] = cmp_s;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic ref_lvl;
	logic ref_rise;
	logic ref_fall;
	logic ref_event;
	logic pause_now;
	logic active;
	logic sample;
	logic start_req;
	logic [CNT_W-1:0] fill_inc;
	logic [CNT_W-1:0] post_inc;
	logic [CNT_W-1:0] addr_last;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.stop_pulse = 1'b0;
		st_nxt.done_pulse = 1'b0;
		st_nxt.wr_en = 1'b0;

		ref_lvl = src_pick(ref_vec, cfg_ref_src);
		ref_rise = ref_lvl & ~st_r.ref_prev;
		ref_fall = ~ref_lvl & st_r.ref_prev;
		st_nxt.ref_prev = ref_lvl;
		if (cfg_ref_src == `ART_SRC_W'(`ART_REF_SRC_CMP))
		begin
			ref_event = ref_rise;
		end
		else
		begin
			ref_event = cfg_ref_edge_fall ? ref_fall : ref_rise;
		end

		// level only: no edge history kept for the pause source
		pause_now = cfg_pause_enable & (src_pick(pause_vec, cfg_pause_src) ^ cfg_pause_active_low);
		st_nxt.pause = pause_now;

		active = (st_r.state == art_pkg::ART_PRE) || (st_r.state == art_pkg::ART_ARMED)
			|| (st_r.state == art_pkg::ART_POST);
		sample = acq_sample_strobe_in & active & ~pause_now;
		if ((st_r.state == art_pkg::ART_POST) && (st_r.post_cnt >= st_r.post_tgt))
		begin
			sample = 1'b0;
		end
		start_req = cfg_start_use_trig ? acq_begin_trigger : sw_start;

		fill_inc = CNT_W'(st_r.fill + 1'b1);
		post_inc = CNT_W'(st_r.post_cnt + 1'b1);
		addr_last = CNT_W'(cfg_buf_size - 1'b1);

		if (sample)
		begin
			st_nxt.wr_en = 1'b1;
			st_nxt.wr_data = sample_data;
			if ((st_r.wr_addr >= addr_last) || (cfg_buf_size == '0))
			begin
				st_nxt.wr_addr = '0;
			end
			else
			begin
				st_nxt.wr_addr = CNT_W'(st_r.wr_addr + 1'b1);
			end
			if (st_r.fill >= cfg_buf_size)
			begin
				st_nxt.wrapped = 1'b1;
			end
			else
			begin
				st_nxt.fill = fill_inc;
			end
		end

		case (st_r.state)
			art_pkg::ART_IDLE:
			begin
				if (start_req)
				begin
					st_nxt.wr_addr = '0;
					st_nxt.fill = '0;
					st_nxt.post_cnt = '0;
					st_nxt.wrapped = 1'b0;
					if (!cfg_ref_enable)
					begin
						st_nxt.post_tgt = cfg_buf_size;
						st_nxt.state = art_pkg::ART_POST;
					end
					else if (cfg_pre_count == '0)
					begin
						st_nxt.state = art_pkg::ART_ARMED;
					end
					else
					begin
						st_nxt.state = art_pkg::ART_PRE;
					end
				end
			end
			art_pkg::ART_PRE:
			begin
				// stop conditions are not looked at here
				if (sample && (fill_inc >= cfg_pre_count))
				begin
					st_nxt.state = art_pkg::ART_ARMED;
				end
			end
			art_pkg::ART_ARMED:
			begin
				if (ref_event)
				begin
					st_nxt.stop_pulse = 1'b1;
					st_nxt.trig_addr = st_nxt.wr_addr;
					st_nxt.post_cnt = '0;
					if (cfg_pre_count > cfg_buf_size)
					begin
						st_nxt.post_tgt = '0;
					end
					else
					begin
						st_nxt.post_tgt = CNT_W'(cfg_buf_size - cfg_pre_count);
					end
					st_nxt.state = art_pkg::ART_POST;
				end
			end
			art_pkg::ART_POST:
			begin
				if (sample)
				begin
					st_nxt.post_cnt = post_inc;
				end
				if ((st_r.post_cnt >= st_r.post_tgt) || (sample && (post_inc >= st_r.post_tgt)))
				begin
					st_nxt.state = art_pkg::ART_DONE;
				end
			end
			art_pkg::ART_DONE:
			begin
				// only a new start leaves idle again
				st_nxt.done_pulse = 1'b1;
				st_nxt.state = art_pkg::ART_IDLE;
			end
			default:
			begin
				st_nxt.state = art_pkg::ART_IDLE;
			end
		endcase

		if (sw_stop && active)
		begin
			st_nxt.state = art_pkg::ART_DONE;
		end

		// pin drive: stop routing has priority over pause routing, so a pin or line routed to both carries only the stop pulse
		for (int i = 0; i < `ART_NUM_PFI; i++)
		begin
			st_nxt.pfi_out[i] = cfg_pfi_ref_out[i] ? st_nxt.stop_pulse : st_nxt.pause;
			st_nxt.pfi_oe[i] = cfg_pfi_ref_out[i] | cfg_pfi_pause_out[i];
		end
		for (int j = 0; j < `ART_NUM_BUS; j++)
		begin
			st_nxt.bus_out[j] = cfg_bus_ref_out[j] ? st_nxt.stop_pulse : st_nxt.pause;
			st_nxt.bus_oe[j] = cfg_bus_ref_out[j] | cfg_bus_pause_out[j];
		end
		st_nxt.star_out = (cfg_star_ref_out & st_nxt.stop_pulse)
			| (~cfg_star_ref_out & cfg_star_pause_out & st_nxt.pause);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r <= ST_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign programmable_function_pin_out = st_r.pfi_out;
	assign programmable_function_pin_oe = st_r.pfi_oe;
	assign sync_trigger_bus_line_out = st_r.bus_out;
	assign sync_trigger_bus_line_oe = st_r.bus_oe;
	assign star_output_line = st_r.star_out;
	assign acq_sample_strobe = st_r.wr_en;
	assign buf_wr_en = st_r.wr_en;
	assign buf_wr_addr = st_r.wr_addr;
	assign buf_wr_data = st_r.wr_data;
	assign trig_addr = st_r.trig_addr;
	assign buf_wrapped = st_r.wrapped;
	assign acq_stop_trigger = st_r.stop_pulse;
	assign acq_pause_gate = st_r.pause;
	assign acq_running = (st_r.state == art_pkg::ART_PRE) || (st_r.state == art_pkg::ART_ARMED)
		|| (st_r.state == art_pkg::ART_POST);
	assign acq_done = st_r.done_pulse;

endmodule

// ==== verification/art_trigger_assertions.sv ====
// Purpose: port checks of art_trigger
// Assumes: one clock, async low reset
// Notes: bound after the module
module art_trigger_assertions
#(
	parameter int CNT_W = 16
)
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [CNT_W-1:0] cfg_buf_size,
	input wire logic cfg_start_use_trig,
	input wire logic sw_start,
	input wire logic cfg_pause_enable,
	input wire logic acq_sample_strobe_in,
	input wire logic acq_sample_strobe,
	input wire logic buf_wr_en,
	input wire logic [CNT_W-1:0] buf_wr_addr,
	input wire logic acq_stop_trigger,
	input wire logic acq_pause_gate,
	input wire logic acq_running,
	input wire logic acq_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	// ------
	// checks
	// ------
	chk_idle_drop: assert property (!acq_running |=> !buf_wr_en)
		else $error("write while idle");
	chk_strobe_pair: assert property (buf_wr_en == acq_sample_strobe)
		else $error("strobe and write differ");
	chk_write_cause: assert property (buf_wr_en |-> $past(acq_sample_strobe_in) && $past(acq_running))
		else $error("write without strobe");
	chk_pause_block: assert property (acq_pause_gate |-> !buf_wr_en)
		else $error("write while paused");
	chk_pause_off: assert property (!cfg_pause_enable |=> !acq_pause_gate)
		else $error("pause while disabled");
	chk_stop_single: assert property (acq_stop_trigger |=> !acq_stop_trigger [*4])
		else $error("stop repeated");
	chk_done_follow: assert property ($fell(acq_running) |=> acq_done)
		else $error("no done pulse");
	chk_done_idle: assert property (acq_done |-> !acq_running && !$past(acq_running))
		else $error("done while running");
	chk_start_go: assert property (!acq_running && !$fell(acq_running) && sw_start
		&& !cfg_start_use_trig |=> acq_running)
		else $error("start not taken");
	chk_addr_range: assert property (acq_running && cfg_buf_size != 0 |-> buf_wr_addr < cfg_buf_size)
		else $error("address past buffer");
	chk_addr_step: assert property (buf_wr_en && cfg_buf_size != 0 |-> buf_wr_addr ==
		(($past(buf_wr_addr) == cfg_buf_size - 1'b1) ? '0 : $past(buf_wr_addr) + 1'b1))
		else $error("address step wrong");
	cov_stop: cover property (acq_stop_trigger);
	cov_pause: cover property (acq_pause_gate && acq_sample_strobe_in);
	cov_done: cover property (acq_done);
endmodule

bind art_trigger art_trigger_assertions #(.CNT_W(CNT_W)) u_art_trigger_assertions (.*);

// ==== verification/art_src_model.sv ====
// Purpose: sample source of the trigger block
// Assumes: strobe every cycle, or every other when slow
// Notes: data line inverts between strobes
module art_src_model
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic slow,
	output logic strobe,
	output logic [15:0] data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ph;
	logic go;
	logic [15:0] cnt;
	assign go = run && (!slow || ph);
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			{ph, strobe, data, cnt} <= '0;
		else
		begin
			ph <= !ph;
			strobe <= go;
			data <= go ? cnt : ~data;
			if (go)
				cnt <= cnt + 16'h0001;
		end
	end
endmodule

// ==== verification/art_trigger_tb_top.sv ====
// Purpose: self-checking bench of art_trigger
// Assumes: default widths
// Notes: rows run stop-trigger captures
module art_trigger_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int bsz; int pre; int src; logic fall; logic trig;} art_row_t;
	logic sys_clk, arst_n, cfg_ref_enable, cfg_ref_edge_fall, cfg_start_use_trig, sw_start, sw_stop;
	logic acq_begin_trigger, cfg_pause_enable, cfg_pause_active_low, cfg_star_ref_out, cfg_star_pause_out;
	logic star_in, comparator_in, change_detect, acq_sample_strobe_in, star_output_line, acq_sample_strobe;
	logic buf_wr_en, buf_wrapped, acq_stop_trigger, acq_pause_gate, acq_running, acq_done, seen, run, slow;
	logic [15:0] cfg_buf_size, cfg_pre_count, cfg_pfi_ref_out, cfg_pfi_pause_out, sample_data, dprev;
	logic [15:0] buf_wr_addr, buf_wr_data, trig_addr, programmable_function_pin_in;
	logic [15:0] programmable_function_pin_out, programmable_function_pin_oe;
	logic [7:0] cfg_bus_ref_out, cfg_bus_pause_out, sync_trigger_bus_line_in;
	logic [7:0] sync_trigger_bus_line_out, sync_trigger_bus_line_oe;
	logic [5:0] cfg_ref_src, cfg_pause_src;
	logic [3:0] ctr_out, ctr_gate;
	logic [2:0] other_stop_trig, other_pause_trig;
	int n_fail, samples_checked, nwr, npost, nstop, ndone, n0;
	art_row_t rows [7] = '{'{12,6,3,0,0}, '{12,5,21,1,0}, '{10,4,24,0,1}, '{6,0,25,1,0},
		'{8,8,27,0,0}, '{9,2,31,0,0}, '{10,3,33,1,0}};

	art_trigger u_art_trigger (.*);
	art_src_model u_art_src_model (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .slow(slow),
		.strobe(acq_sample_strobe_in), .data(sample_data));

	// ------
	// helpers
	// ------
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic set_src(input int s, input logic v);
		if (s < 16) programmable_function_pin_in[s] <= v;
		else if (s < 24) sync_trigger_bus_line_in[s-16] <= v;
		else if (s == 24) star_in <= v;
		else if (s == 25) change_detect <= v;
		else if (s < 30) ctr_out[s-26] <= v;
		else if (s < 33) other_stop_trig[s-30] <= v;
		else comparator_in <= v;
	endtask

	task automatic wait_done();
		int k;
		k = 0;
		while (ndone == 0 && k < 300)
		begin
			@(posedge sys_clk);
			k++;
		end
		check("done seen", 16'(ndone), 16'h0001);
	endtask

	task automatic run_row(input art_row_t r);
		logic idle;
		idle = r.fall && r.src != 33;
		@(posedge sys_clk);
		set_src(r.src, idle);
		cfg_buf_size <= 16'(r.bsz);
		cfg_pre_count <= 16'(r.pre);
		cfg_ref_src <= 6'(r.src);
		cfg_ref_edge_fall <= r.fall;
		cfg_start_use_trig <= r.trig;
		cfg_ref_enable <= 1'b1;
		repeat (4) @(posedge sys_clk);
		{nwr, npost, nstop, ndone, seen} = '0;
		if (r.trig) acq_begin_trigger <= 1'b1;
		else sw_start <= 1'b1;
		if (r.pre > 0) set_src(r.src, !idle);
		@(posedge sys_clk);
		acq_begin_trigger <= 1'b0;
		sw_start <= 1'b0;
		run <= 1'b1;
		set_src(r.src, idle);
		repeat (2 * r.bsz + 4) @(posedge sys_clk);
		set_src(r.src, !idle);
		wait_done();
		set_src(r.src, idle);
		repeat (3) @(posedge sys_clk);
		set_src(r.src, !idle);
		repeat (6) @(posedge sys_clk);
		run <= 1'b0;
		check("stop count", 16'(nstop), 16'h0001);
		check("post samples", 16'(npost), 16'(r.bsz - r.pre));
		check("running", acq_running, 1'b0);
	endtask

	// ------
	// stimulus
	// ------
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		report_and_stop();
	end

	always @(posedge sys_clk)
	begin
		if (buf_wr_en)
		begin
			nwr++;
			check("wr data", buf_wr_data, dprev);
			if (seen)
				npost++;
		end
		if (acq_stop_trigger)
		begin
			nstop++;
			seen = 1'b1;
			check("stop pin", programmable_function_pin_out[2], 1'b1);
			check("stop bus", sync_trigger_bus_line_out[0], 1'b1);
			check("stop star", star_output_line, 1'b1);
			check("wrapped", buf_wrapped, 1'b1);
			check("trig addr", trig_addr, 16'(nwr % cfg_buf_size));
		end
		if (acq_done)
			ndone++;
		if (acq_sample_strobe_in)
			dprev = sample_data;
	end

	initial
	begin
		{arst_n, cfg_ref_enable, cfg_ref_edge_fall, cfg_start_use_trig, sw_start, sw_stop} = '0;
		{acq_begin_trigger, cfg_pause_enable, cfg_pause_active_low, cfg_star_pause_out} = '0;
		{star_in, comparator_in, change_detect, run, slow, seen, dprev} = '0;
		{cfg_buf_size, cfg_pre_count, cfg_pfi_pause_out, programmable_function_pin_in} = '0;
		{cfg_bus_pause_out, sync_trigger_bus_line_in, cfg_ref_src, cfg_pause_src, ctr_out, ctr_gate} = '0;
		{other_stop_trig, other_pause_trig} = '0;
		cfg_pfi_ref_out = 16'h0004;
		cfg_bus_ref_out = 8'h01;
		cfg_star_ref_out = 1'b1;
		repeat (20) @(posedge sys_clk);
		check("pin oe in reset", programmable_function_pin_oe, 16'h0000);
		check("bus oe in reset", 16'(sync_trigger_bus_line_oe), 16'h0000);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check("pin oe", programmable_function_pin_oe, 16'h0004);
		$display("reset test done");
		foreach (rows[i])
		begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		cfg_ref_enable <= 1'b0;
		cfg_buf_size <= 16'h000a;
		cfg_pause_enable <= 1'b1;
		cfg_pause_src <= 6'h1e;
		cfg_pause_active_low <= 1'b1;
		ctr_gate <= 4'h2;
		cfg_pfi_pause_out <= 16'h0020;
		cfg_star_pause_out <= 1'b1;
		cfg_star_ref_out <= 1'b0;
		repeat (3) @(posedge sys_clk);
		{nwr, ndone} = '0;
		sw_start <= 1'b1;
		slow <= 1'b1;
		@(posedge sys_clk);
		sw_start <= 1'b0;
		run <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ctr_gate <= 4'h0;
		repeat (3) @(posedge sys_clk);
		n0 = nwr;
		check("pause gate", acq_pause_gate, 1'b1);
		check("pause pin", programmable_function_pin_out[5], 1'b1);
		check("pause star", star_output_line, 1'b1);
		repeat (8) @(posedge sys_clk);
		check("paused writes", 16'(nwr - n0), 16'h0000);
		ctr_gate <= 4'h2;
		wait_done();
		check("finite writes", 16'(nwr), 16'h000a);
		run <= 1'b0;
		cfg_pause_src <= 6'h24;
		cfg_pause_active_low <= 1'b0;
		comparator_in <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check("cmp pause", acq_pause_gate, 1'b1);
		comparator_in <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check("cmp resume", acq_pause_gate, 1'b0);
		$display("pause test done");
		ndone = 0;
		cfg_buf_size <= 16'h0100;
		sw_start <= 1'b1;
		run <= 1'b1;
		@(posedge sys_clk);
		sw_start <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check("abort running", acq_running, 1'b1);
		sw_stop <= 1'b1;
		@(posedge sys_clk);
		sw_stop <= 1'b0;
		wait_done();
		check("abort idle", acq_running, 1'b0);
		n0 = nwr;
		repeat (5) @(posedge sys_clk);
		check("idle writes", 16'(nwr - n0), 16'h0000);
		run <= 1'b0;
		$display("abort test done");
		report_and_stop();
	end
endmodule
